// >>> logic/bvp_pkg.sv
`default_nettype none
package bvp_pkg;
    // Bus widths toward the flash pins and synchroniser depth
    localparam int ADDR_W   = 22;
    localparam int DQ_W     = 16;
    localparam int SYNC_N   = 3;
    // Clock period and bus timing in ns
    localparam int CLK_NS    = 4;
    localparam int T_WP_NS   = 40;
    localparam int T_WPH_NS  = 20;
    localparam int T_ACC_NS  = 80;
    localparam int T_BUSY_NS = 200;
    // Least times rounded up to whole cycles
    localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_N;
    localparam int BUSY_CYC = (T_BUSY_NS + CLK_NS - 1) / CLK_NS;
    // Command data codes
    localparam logic [7:0] D_PROG   = 8'hA0;
    localparam logic [7:0] D_BUF    = 8'h25;
    localparam logic [7:0] D_ERASE  = 8'h80;
    localparam logic [7:0] D_RSTENT = 8'h90;
    localparam logic [7:0] D_EXIT   = 8'h00;
    localparam logic [7:0] D_VP_CLR = 8'h01;
    localparam logic [7:0] D_CHIP   = 8'h10;
    localparam logic [7:0] D_SECT   = 8'h30;
    localparam logic [7:0] D_ESUSP  = 8'hB0;
    localparam logic [7:0] D_PSUSP  = 8'h51;
    localparam logic [7:0] D_PRES   = 8'h50;
    localparam logic [7:0] D_CONF   = 8'h29;
    localparam logic [7:0] D_RESET  = 8'hF0;
    localparam logic [7:0] D_STAT   = 8'h70;
    // Status command address and status bit positions
    localparam logic [ADDR_W-1:0] A_STAT = 22'h000555;
    localparam int SR_READY   = 7;
    localparam int SR_TIMEOUT = 5;
    // Sector field and buffer limits
    localparam int SECT_LSB = 12;
    localparam logic [DQ_W-1:0] WC_MAX = 16'h007F;
    localparam logic [7:0] WC_LAST = 8'hFF;
    // Host orders
    typedef enum logic [4:0] {
        OP_RAW, OP_ENTER_BYPASS, OP_ENTER_VP, OP_WORD_ENTRY, OP_BUF_ENTRY,
        OP_ERASE_ENTRY, OP_RESET_ENTRY, OP_EXIT, OP_CHIP_ERASE, OP_SECTOR_ERASE,
        OP_SUSPEND, OP_RESUME, OP_DATA, OP_CONFIRM, OP_RESET, OP_STATUS,
        OP_VP_SET, OP_VP_CLEAR
    } bvp_op_t;
    // Mirror of the device command state
    typedef enum logic [4:0] {
        S_READ, S_BYP_IDLE, S_RESET_ENTRY, S_ERASE_ENTRY, S_CHIP_ERASING,
        S_SECTOR_ERASING, S_ESUSP_REQ, S_ERASE_SUSP, S_BUF_ENTRY, S_BUF_LOADING,
        S_WORD_ENTRY, S_PROGRAMMING, S_PSUSP_REQ, S_PROG_SUSP, S_HANG,
        S_VP_MODE, S_VP_SET, S_VP_EXIT
    } bvp_state_t;
    // Bus sequencer phases
    typedef enum logic [1:0] {PH_IDLE, PH_WR, PH_WH, PH_RD} bvp_phase_t;
    // User order
    typedef struct packed {
        bvp_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DQ_W-1:0]     data;
    } bvp_req_t;
    // Flash pin drive
    typedef struct packed {
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic [ADDR_W-1:0]   addr;
        logic [DQ_W-1:0]     dq_out;
        logic                dq_oe;
    } bvp_pins_t;
    // Result of a transition check
    typedef struct packed {
        logic                ok;
        bvp_state_t          nxt;
    } bvp_tr_t;
endpackage
`default_nettype wire

// >>> logic/bvp_host.sv
// Function
// - Bypass idle takes A0, 25, 80, 90 entries
// - Erase entry starts chip or sector erase
// - Erase timeout hangs until F0 reset
// - B0 suspends sector erase after latency
// - Suspended erase takes resume, program, buffer entries
// - Use enhanced 51 suspend, legacy names noted
// - Buffer sector mismatch or count over 127 faults
// - Confirm 29 at sector after count reaches -1
// - 51 suspends program after latency, only when it started from erase suspend
// - Program timeout hangs until F0 reset
// - Volatile protection set, clear and exit writes
`timescale 1ns/100ps
`default_nettype none
module bvp_host
    import bvp_pkg::*;
#(
    parameter int ESUSP_LAT_NS = 20000,
    parameter int PSUSP_LAT_NS = 20000
)(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             req_valid,
    input  wire bvp_req_t         req,
    output logic                  req_ready,
    output logic                  rsp_done,
    output logic                  rsp_err,
    output logic [7:0]            status,
    output bvp_state_t            mode,
    output bvp_pins_t             pins,
    input  wire logic [DQ_W-1:0]  flash_dq_in,
    input  wire logic             flash_ry
);
    // Longest latencies rounded down to cycles
    localparam logic [15:0] ESL_CYC = 16'(ESUSP_LAT_NS / CLK_NS);
    localparam logic [15:0] PSL_CYC = 16'(PSUSP_LAT_NS / CLK_NS);

    bvp_state_t         state_q, state_d;     // Device state mirror
    bvp_phase_t         ph_q, ph_d;           // Bus phase
    bvp_pins_t          pins_q, pins_d;       // Pin drive
    logic               susp_q, susp_d;       // Program started from erase suspend
    logic               rd_q, rd_d;           // Read follows the write
    logic               auto_q, auto_d;       // Completion status read
    logic [7:0]         wc_q, wc_d;           // Buffer word count
    logic [ADDR_W-SECT_LSB-1:0] sect_q, sect_d; // Buffer sector
    logic [15:0]        cnt_q, cnt_d;         // Phase timer
    logic [15:0]        lat_q, lat_d;         // Suspend latency timer
    logic [15:0]        hold_q, hold_d;       // Busy hold-off timer
    logic [DQ_W:0]      sy1_q, sy2_q, sy3_q;  // Pin synchroniser
    logic [DQ_W:0]      filt_q, filt_d;       // Agreed pin levels
    logic [7:0]         status_q, status_d;   // Last status byte
    logic               ready_q, ready_d;
    logic               done_q, done_d;
    logic               err_q, err_d;
    bvp_tr_t            tr;

    // Sector field of an address
    function automatic logic [ADDR_W-SECT_LSB-1:0] sect_of(input logic [ADDR_W-1:0] a);
        sect_of = a[ADDR_W-1:SECT_LSB];
    endfunction

    // Legal next state for an order
    function automatic bvp_tr_t next_of(input bvp_state_t st, input bvp_op_t op,
                                        input logic susp, input logic [7:0] wc,
                                        input logic sm, input logic [DQ_W-1:0] d);
        bvp_tr_t r;
        r.ok  = 1'b1;
        r.nxt = st;
        case (st)
            S_READ:
                if (op == OP_ENTER_BYPASS) r.nxt = S_BYP_IDLE;
                else if (op == OP_ENTER_VP) r.nxt = S_VP_MODE;
                else r.ok = (op == OP_RAW);
            S_BYP_IDLE:
                if (op == OP_WORD_ENTRY) r.nxt = S_WORD_ENTRY;
                else if (op == OP_BUF_ENTRY) r.nxt = S_BUF_ENTRY;
                else if (op == OP_ERASE_ENTRY) r.nxt = S_ERASE_ENTRY;
                else if (op == OP_RESET_ENTRY) r.nxt = S_RESET_ENTRY;
                else r.ok = (op == OP_STATUS);
            S_RESET_ENTRY:
                if (op == OP_EXIT) r.nxt = S_READ;
                else r.ok = 1'b0;
            // erase start, status entry falls back to idle
            S_ERASE_ENTRY:
                if (op == OP_CHIP_ERASE) r.nxt = S_CHIP_ERASING;
                else if (op == OP_SECTOR_ERASE) r.nxt = S_SECTOR_ERASING;
                else if (op == OP_STATUS) r.nxt = S_BYP_IDLE;
                else r.ok = 1'b0;
            S_SECTOR_ERASING:
                if (op == OP_SUSPEND) r.nxt = S_ESUSP_REQ;
                else r.ok = (op == OP_STATUS) || (op == OP_SECTOR_ERASE);
            S_ERASE_SUSP:
                if (op == OP_RESUME) r.nxt = S_SECTOR_ERASING;
                else if (op == OP_WORD_ENTRY) r.nxt = S_WORD_ENTRY;
                else if (op == OP_BUF_ENTRY) r.nxt = S_BUF_ENTRY;
                else r.ok = (op == OP_STATUS) || (op == OP_RESET);
            S_BUF_ENTRY:
                if (op == OP_DATA && sm && d <= WC_MAX) r.nxt = S_BUF_LOADING;
                else r.ok = 1'b0;
            S_BUF_LOADING:
                if (wc == WC_LAST) r.ok = (op == OP_CONFIRM) && sm;
                else r.ok = (op == OP_DATA) && sm;
            S_WORD_ENTRY:
                r.ok = (op == OP_DATA);
            // program suspend from erase suspend only
            S_PROGRAMMING:
                if (op == OP_SUSPEND && susp) r.nxt = S_PSUSP_REQ;
                else r.ok = (op == OP_STATUS);
            S_PROG_SUSP:
                if (op == OP_RESUME) r.nxt = S_PROGRAMMING;
                else r.ok = (op == OP_STATUS);
            S_HANG:
                if (op == OP_RESET) r.nxt = susp ? S_ERASE_SUSP : S_BYP_IDLE;
                else r.ok = 1'b0;
            S_VP_MODE:
                if (op == OP_RESET_ENTRY) r.nxt = S_VP_EXIT;
                else if (op == OP_WORD_ENTRY) r.nxt = S_VP_SET;
                else if (op == OP_RESET) r.nxt = S_READ;
                else r.ok = (op == OP_STATUS);
            S_VP_SET:
                if (op == OP_VP_SET || op == OP_VP_CLEAR || op == OP_EXIT) r.nxt = S_VP_MODE;
                else r.ok = 1'b0;
            S_VP_EXIT:
                if (op == OP_EXIT) r.nxt = S_READ;
                else r.ok = 1'b0;
            S_CHIP_ERASING, S_ESUSP_REQ, S_PSUSP_REQ:
                r.ok = (op == OP_STATUS);
            default:
                r.ok = 1'b0;
        endcase
        if (st == S_BUF_LOADING && r.ok && op == OP_CONFIRM) r.nxt = S_PROGRAMMING;
        if (st == S_WORD_ENTRY && r.ok) r.nxt = S_PROGRAMMING;
        next_of = r;
    endfunction

    // Data placed on the bus for an order
    function automatic logic [DQ_W-1:0] data_of(input bvp_op_t op, input bvp_state_t st,
                                                input logic [DQ_W-1:0] d);
        logic [7:0] c;
        c = 8'h00;
        case (op)
            OP_WORD_ENTRY:   c = D_PROG;
            OP_BUF_ENTRY:    c = D_BUF;
            OP_ERASE_ENTRY:  c = D_ERASE;
            OP_RESET_ENTRY:  c = D_RSTENT;
            OP_CHIP_ERASE:   c = D_CHIP;
            OP_SECTOR_ERASE: c = D_SECT;
            // enhanced codes where a choice exists
            OP_SUSPEND:      c = (st == S_PROGRAMMING) ? D_PSUSP : D_ESUSP;
            OP_RESUME:       c = (st == S_PROG_SUSP) ? D_PRES : D_SECT;
            OP_CONFIRM:      c = D_CONF;
            OP_RESET:        c = D_RESET;
            OP_STATUS:       c = D_STAT;
            OP_VP_CLEAR:     c = D_VP_CLR;
            default:         c = D_EXIT;
        endcase
        if (op == OP_RAW || op == OP_DATA || op == OP_ENTER_BYPASS || op == OP_ENTER_VP)
            data_of = d;
        else
            data_of = {{(DQ_W-8){1'b0}}, c};
    endfunction

    assign tr = next_of(state_q, req.op, susp_q, wc_q, sect_of(req.addr) == sect_q, req.data);

    // Next-value logic for all state
    always_comb
    begin
        state_d  = state_q;
        ph_d     = ph_q;
        pins_d   = pins_q;
        susp_d   = susp_q;
        rd_d     = rd_q;
        auto_d   = auto_q;
        wc_d     = wc_q;
        sect_d   = sect_q;
        status_d = status_q;
        done_d   = 1'b0;
        err_d    = 1'b0;
        cnt_d    = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
        lat_d    = (lat_q != 16'h0000) ? lat_q - 16'h0001 : lat_q;
        hold_d   = (hold_q != 16'h0000) ? hold_q - 16'h0001 : hold_q;
        // Agreement of the last two synchroniser stages
        filt_d   = (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & filt_q);
        case (ph_q)
            // Take an order, or poll a finished operation
            PH_IDLE:
                if (req_valid && ready_q)
                begin
                    if (tr.ok)
                    begin
                        state_d = tr.nxt;
                        if (req.op == OP_BUF_ENTRY) sect_d = sect_of(req.addr);
                        if (req.op == OP_WORD_ENTRY || req.op == OP_BUF_ENTRY)
                            susp_d = (state_q == S_ERASE_SUSP);
                        if (req.op == OP_RESUME && state_q == S_ERASE_SUSP) susp_d = 1'b0;
                        if (state_q == S_BUF_ENTRY) wc_d = req.data[7:0];
                        if (state_q == S_BUF_LOADING && req.op == OP_DATA) wc_d = wc_q - 8'h01;
                        rd_d          = (req.op == OP_STATUS);
                        pins_d.ce_n   = 1'b0;
                        pins_d.we_n   = 1'b0;
                        pins_d.dq_oe  = 1'b1;
                        pins_d.addr   = (req.op == OP_STATUS) ? A_STAT : req.addr;
                        pins_d.dq_out = data_of(req.op, state_q, req.data);
                        ph_d          = PH_WR;
                        cnt_d         = 16'(WP_CYC - 1);
                        hold_d        = 16'(BUSY_CYC);
                    end
                    else
                        err_d = 1'b1;
                end
                else if ((state_q == S_CHIP_ERASING || state_q == S_SECTOR_ERASING ||
                          state_q == S_PROGRAMMING) && hold_q == 16'h0000 && filt_q[DQ_W])
                begin
                    auto_d        = 1'b1;
                    rd_d          = 1'b1;
                    pins_d.ce_n   = 1'b0;
                    pins_d.we_n   = 1'b0;
                    pins_d.dq_oe  = 1'b1;
                    pins_d.addr   = A_STAT;
                    pins_d.dq_out = {{(DQ_W-8){1'b0}}, D_STAT};
                    ph_d          = PH_WR;
                    cnt_d         = 16'(WP_CYC - 1);
                end
            // Write strobe low time
            PH_WR:
                if (cnt_q == 16'h0000)
                begin
                    pins_d.we_n = 1'b1;
                    ph_d        = PH_WH;
                    cnt_d       = 16'(WPH_CYC - 1);
                end
            // Data hold, then release or read
            PH_WH:
                if (cnt_q == 16'h0000)
                begin
                    pins_d.dq_oe = 1'b0;
                    if (rd_q)
                    begin
                        pins_d.oe_n = 1'b0;
                        ph_d        = PH_RD;
                        cnt_d       = 16'(ACC_CYC - 1);
                    end
                    else
                    begin
                        pins_d.ce_n = 1'b1;
                        ph_d        = PH_IDLE;
                        done_d      = ~auto_q;
                    end
                end
            // Status sample and completion outcome
            PH_RD:
                if (cnt_q == 16'h0000)
                begin
                    status_d    = filt_q[7:0];
                    pins_d.ce_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    ph_d        = PH_IDLE;
                    rd_d        = 1'b0;
                    done_d      = ~auto_q;
                    auto_d      = 1'b0;
                    if (auto_q && filt_q[SR_READY])
                    begin
                        if (filt_q[SR_TIMEOUT]) state_d = S_HANG;
                        else state_d = susp_q ? S_ERASE_SUSP : S_BYP_IDLE;
                    end
                end
            default:
                ph_d = PH_IDLE;
        endcase
        if (state_q == S_ESUSP_REQ && lat_q == 16'h0000) state_d = S_ERASE_SUSP;
        if (state_q == S_PSUSP_REQ && lat_q == 16'h0000) state_d = S_PROG_SUSP;
        if (state_d == S_ESUSP_REQ && state_q != S_ESUSP_REQ) lat_d = ESL_CYC;
        if (state_d == S_PSUSP_REQ && state_q != S_PSUSP_REQ) lat_d = PSL_CYC;
        ready_d = (ph_d == PH_IDLE);
    end

    // Register stage with clock enable
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q  <= S_READ;
            ph_q     <= PH_IDLE;
            pins_q   <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
            susp_q   <= 1'b0;
            rd_q     <= 1'b0;
            auto_q   <= 1'b0;
            wc_q     <= 8'h00;
            sect_q   <= '0;
            cnt_q    <= 16'h0000;
            lat_q    <= 16'h0000;
            hold_q   <= 16'h0000;
            sy1_q    <= '0;
            sy2_q    <= '0;
            sy3_q    <= '0;
            filt_q   <= '0;
            status_q <= 8'h00;
            ready_q  <= 1'b0;
            done_q   <= 1'b0;
            err_q    <= 1'b0;
        end
        else if (ce)
        begin
            state_q  <= state_d;
            ph_q     <= ph_d;
            pins_q   <= pins_d;
            susp_q   <= susp_d;
            rd_q     <= rd_d;
            auto_q   <= auto_d;
            wc_q     <= wc_d;
            sect_q   <= sect_d;
            cnt_q    <= cnt_d;
            lat_q    <= lat_d;
            hold_q   <= hold_d;
            sy1_q    <= {flash_ry, flash_dq_in};
            sy2_q    <= sy1_q;
            sy3_q    <= sy2_q;
            filt_q   <= filt_d;
            status_q <= status_d;
            ready_q  <= ready_d;
            done_q   <= done_d;
            err_q    <= err_d;
        end
    end

    assign req_ready = ready_q;
    assign rsp_done  = done_q;
    assign rsp_err   = err_q;
    assign status    = status_q;
    assign mode      = state_q;
    assign pins      = pins_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_BYPASS_ENTRY: assert property (ce && state_q == S_BYP_IDLE && state_d == S_WORD_ENTRY
        |=> pins_q.dq_out[7:0] == D_PROG && !pins_q.we_n) else $error("word entry data wrong");
    AST_ERASE_START: assert property (state_q == S_ERASE_ENTRY ##1 state_q == S_CHIP_ERASING
        |-> pins_q.dq_out[7:0] == D_CHIP) else $error("chip erase data wrong");
    AST_HANG_RESET: assert property (state_q == S_HANG ##1 state_q != S_HANG
        |-> pins_q.dq_out[7:0] == D_RESET && !pins_q.we_n) else $error("hang left without reset");
    AST_ESUSP_LATENCY: assert property (ce && state_q == S_ESUSP_REQ && lat_q == 16'h0000
        |=> state_q == S_ERASE_SUSP) else $error("erase suspend latency missed");
    AST_ERASE_RESUME: assert property (state_q == S_ERASE_SUSP ##1 state_q == S_SECTOR_ERASING
        |-> pins_q.dq_out[7:0] == D_SECT && !susp_q) else $error("erase resume wrong");
    AST_PROG_SUSPEND: assert property (state_q == S_PROGRAMMING ##1 state_q == S_PSUSP_REQ
        |-> pins_q.dq_out[7:0] == D_PSUSP && lat_q == PSL_CYC) else $error("program suspend wrong");
    AST_BUF_SECTOR: assert property (ce && ph_q == PH_IDLE && ph_d == PH_WR
        && (state_q == S_BUF_ENTRY || state_q == S_BUF_LOADING) |-> sect_of(req.addr) == sect_q)
        else $error("buffer sector mismatch issued");
    AST_CONFIRM: assert property (state_q == S_BUF_LOADING ##1 state_q == S_PROGRAMMING
        |-> wc_q == WC_LAST && pins_q.dq_out[7:0] == D_CONF) else $error("confirm early");
    AST_HANG_RETURN: assert property (state_q == S_HANG && susp_q ##1 state_q != S_HANG
        |-> state_q == S_ERASE_SUSP) else $error("program hang return wrong");
    AST_VP_WRITE: assert property (state_q == S_VP_SET ##1 state_q == S_VP_MODE
        |-> pins_q.dq_out[7:0] inside {D_EXIT, D_VP_CLR}) else $error("protect write wrong");

    COV_SECTOR_ERASE: cover property (state_q == S_ERASE_ENTRY ##1 state_q == S_SECTOR_ERASING);
    COV_ERASE_SUSPEND: cover property (state_q == S_ESUSP_REQ ##1 state_q == S_ERASE_SUSP);
    COV_BUF_PROGRAM: cover property (state_q == S_BUF_LOADING ##1 state_q == S_PROGRAMMING);
    COV_HANG: cover property (state_q == S_HANG);
endmodule
`default_nettype wire

// >>> dv/bvp_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// Flash model with a busy timer, a status byte and the ready pin
module bvp_flash_model
    import bvp_pkg::*;
#(
    parameter int WORK_CYC = 300
)(
    input  wire logic        clk,
    input  wire bvp_pins_t   pins,
    input  wire logic        tmo,
    output logic [DQ_W-1:0]  dq,
    output logic             ry
);
    int              busy_q  = 0;     // Cycles of work left
    logic            armed_q = 1'b0;  // Word program entry seen
    logic            we_q    = 1'b1;  // Write strobe one cycle ago
    logic [DQ_W-1:0] last_q  = '0;    // Last value driven on DQ
    logic [7:0]      stat;            // Status byte
    logic [7:0]      cmd;             // Data byte of a write
    assign stat = {busy_q == 0, 1'b0, tmo && busy_q == 0, 5'h00};
    assign ry   = busy_q == 0;
    assign cmd  = pins.dq_out[7:0];
    // reads keep state, released DQ shows the inverse
    assign dq   = (!pins.ce_n && !pins.oe_n) ? {8'h00, stat} : ~last_q;
    // Writes are taken on the rising write strobe
    always @(posedge clk)
    begin
        we_q <= pins.we_n;
        if (!pins.ce_n && !pins.oe_n)
            last_q <= dq;
        if (busy_q > 0)
            busy_q <= busy_q - 1;
        if (pins.we_n && !we_q && !pins.ce_n)
        begin
            armed_q <= cmd == D_PROG;
            // work starts on erase, confirm, data or resume
            if (armed_q || cmd inside {D_CHIP, D_SECT, D_CONF, D_PRES})
                busy_q <= WORK_CYC;
            // suspend stops work, other writes do nothing
            else if (cmd inside {D_ESUSP, D_PSUSP})
                busy_q <= 0;
        end
    end
endmodule
`default_nettype wire

// >>> dv/bvp_host_test.sv
`timescale 1ns/100ps
`default_nettype none
module bvp_host_test
    import bvp_pkg::*;
;
    // One order with its expected refusal and settled mode
    typedef struct packed {
        bvp_op_t         op;
        logic [3:0]      sec;
        logic [DQ_W-1:0] data;
        logic            err;
        bvp_state_t      exp;
    } bvp_row_t;
    logic            clk       = 1'b0;  // Bench clock
    logic            rst_n     = 1'b0;  // Synchronous reset
    logic            req_valid = 1'b0;  // Order offered
    bvp_req_t        req       = '0;    // Order
    logic            tmo       = 1'b0;  // Model reports a timeout
    logic            ce        = 1'b1;  // Clock enable
    logic [7:0]      status;            // Last status byte read
    logic            req_ready, rsp_done, rsp_err, ry;
    bvp_state_t      mode;
    bvp_pins_t       pins;
    logic [DQ_W-1:0] dq;
    int              mismatches = 0;
    int              tests_run  = 0;
    bvp_row_t        rows [31] = '{
        '{OP_ENTER_BYPASS,4'h0,16'h0020,1'b0,S_BYP_IDLE}, // entry
        '{OP_RAW,4'h0,16'h00AA,1'b1,S_BYP_IDLE}, // refused
        '{OP_ERASE_ENTRY,4'h0,16'h0000,1'b0,S_ERASE_ENTRY}, // erase
        '{OP_CHIP_ERASE,4'h0,16'h0000,1'b0,S_BYP_IDLE}, // chip
        '{OP_ERASE_ENTRY,4'h0,16'h0000,1'b0,S_ERASE_ENTRY},
        '{OP_SECTOR_ERASE,4'h1,16'h0000,1'b0,S_SECTOR_ERASING}, // sector
        '{OP_SUSPEND,4'h0,16'h0000,1'b0,S_ERASE_SUSP}, // suspend
        '{OP_STATUS,4'h0,16'h0000,1'b0,S_ERASE_SUSP}, // status
        '{OP_RESET,4'h0,16'h0000,1'b0,S_ERASE_SUSP}, // reset
        '{OP_WORD_ENTRY,4'h0,16'h0000,1'b0,S_WORD_ENTRY}, // word
        '{OP_DATA,4'h2,16'h1234,1'b0,S_PROGRAMMING}, // start
        '{OP_SUSPEND,4'h0,16'h0000,1'b0,S_PROG_SUSP}, // suspend
        '{OP_RESUME,4'h0,16'h0000,1'b0,S_ERASE_SUSP}, // return
        '{OP_BUF_ENTRY,4'h3,16'h0000,1'b0,S_BUF_ENTRY}, // buffer
        '{OP_DATA,4'h3,16'h0080,1'b1,S_BUF_ENTRY}, // count 128
        '{OP_DATA,4'h3,16'h0001,1'b0,S_BUF_LOADING}, // count
        '{OP_DATA,4'h4,16'h1234,1'b1,S_BUF_LOADING}, // sector
        '{OP_DATA,4'h3,16'h1111,1'b0,S_BUF_LOADING}, // word
        '{OP_CONFIRM,4'h3,16'h0029,1'b1,S_BUF_LOADING}, // early
        '{OP_DATA,4'h3,16'h2222,1'b0,S_BUF_LOADING}, // last
        '{OP_CONFIRM,4'h3,16'h0029,1'b0,S_ERASE_SUSP}, // confirm
        '{OP_RESUME,4'h0,16'h0000,1'b0,S_BYP_IDLE}, // resume
        '{OP_RESET_ENTRY,4'h0,16'h0000,1'b0,S_RESET_ENTRY}, // reset
        '{OP_EXIT,4'h0,16'h0000,1'b0,S_READ}, // exit
        '{OP_ENTER_VP,4'h0,16'h00E0,1'b0,S_VP_MODE}, // entry
        '{OP_WORD_ENTRY,4'h0,16'h0000,1'b0,S_VP_SET}, // set
        '{OP_VP_SET,4'h7,16'h0000,1'b0,S_VP_MODE}, // protect
        '{OP_WORD_ENTRY,4'h0,16'h0000,1'b0,S_VP_SET},
        '{OP_VP_CLEAR,4'h7,16'h0001,1'b0,S_VP_MODE}, // unprotect
        '{OP_RESET_ENTRY,4'h0,16'h0000,1'b0,S_VP_EXIT}, // exit path
        '{OP_EXIT,4'h0,16'h0000,1'b0,S_READ}}; // exit
    always #2 clk = ~clk;
    bvp_host #(.ESUSP_LAT_NS(40), .PSUSP_LAT_NS(40)) bvp_host_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_done(rsp_done), .rsp_err(rsp_err),
        .status(status), .mode(mode), .pins(pins), .flash_dq_in(dq), .flash_ry(ry));
    bvp_flash_model bvp_flash_model_i (.clk(clk), .pins(pins), .tmo(tmo), .dq(dq), .ry(ry));
    // Counts and ends the run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Compares one value
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // A used-up wait ends the run
    task automatic bound(input int n);
        if (n >= 3000)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask
    // Offers one order, then waits for its answer and its settled mode
    task automatic run(input bvp_row_t r);
        int n;
        for (n = 0; n < 3000 && req_ready !== 1'b1; n++)
            @(negedge clk);
        bound(n);
        req       = '{r.op, 22'(r.sec) << SECT_LSB, r.data};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 3000 && (rsp_done | rsp_err) !== 1'b1; n++)
            @(negedge clk);
        bound(n);
        check(rsp_err, r.err);
        for (n = 0; n < 3000 && mode !== r.exp; n++)
            @(negedge clk);
        check(mode, r.exp);
    endtask
    // Main sequence
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i])
            run(rows[i]);
        run('{OP_ENTER_BYPASS, 4'h0, 16'h0020, 1'b0, S_BYP_IDLE});
        tmo = 1'b1;
        run('{OP_ERASE_ENTRY, 4'h0, 16'h0000, 1'b0, S_ERASE_ENTRY});
        run('{OP_CHIP_ERASE, 4'h0, 16'h0000, 1'b0, S_HANG});
        check(status, (32'h1 << SR_READY) | (32'h1 << SR_TIMEOUT));
        tmo = 1'b0;
        run('{OP_RESET, 4'h0, 16'h0000, 1'b0, S_BYP_IDLE});
        // Clock enable low freezes an offered order
        ce        = 1'b0;
        req       = '{OP_ERASE_ENTRY, '0, '0};
        req_valid = 1'b1;
        repeat (3) @(negedge clk);
        check({mode, req_ready}, {S_BYP_IDLE, 1'b1});
        req_valid = 1'b0;
        ce        = 1'b1;
        // Status in erase entry, added sector, program timeout in suspend
        run('{OP_ERASE_ENTRY, 4'h0, 16'h0000, 1'b0, S_ERASE_ENTRY});
        run('{OP_STATUS, 4'h0, 16'h0000, 1'b0, S_BYP_IDLE});
        check(status, 32'h1 << SR_READY);
        run('{OP_ERASE_ENTRY, 4'h0, 16'h0000, 1'b0, S_ERASE_ENTRY});
        run('{OP_SECTOR_ERASE, 4'h1, 16'h0000, 1'b0, S_SECTOR_ERASING});
        run('{OP_SECTOR_ERASE, 4'h2, 16'h0000, 1'b0, S_SECTOR_ERASING});
        run('{OP_SUSPEND, 4'h0, 16'h0000, 1'b0, S_ERASE_SUSP});
        run('{OP_WORD_ENTRY, 4'h0, 16'h0000, 1'b0, S_WORD_ENTRY});
        tmo = 1'b1;
        run('{OP_DATA, 4'h2, 16'h1234, 1'b0, S_HANG});
        check(status, (32'h1 << SR_READY) | (32'h1 << SR_TIMEOUT));
        tmo = 1'b0;
        run('{OP_RESET, 4'h0, 16'h0000, 1'b0, S_ERASE_SUSP});
        // Mid-run reset idles the pins and returns to read mode
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        check(mode, S_READ);
        check({pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe, req_ready}, 5'h1C);
        rst_n = 1'b1;
        @(negedge clk);
        check(req_ready, 1'b1);
        run('{OP_ENTER_VP, 4'h0, 16'h00E0, 1'b0, S_VP_MODE});
        run('{OP_RESET, 4'h0, 16'h0000, 1'b0, S_READ});
        report_and_stop();
    end
endmodule
`default_nettype wire
